// [hw/pcam_pkg.sv]
// Package: register map, mode fields and timing constants of the counter array
package pcam_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CNT_LOW = 8'hF9;
  localparam logic [7:0] IDX_CNT_HIGH = 8'hFA;
  localparam logic [7:0] IDX_CTRL = 8'hD7;
  localparam logic [7:0] IDX_FLAGS = 8'hD8;
  localparam logic [7:0] IDX_CYCLE = 8'hD9;
  // Per-module indices, module 0 in the low byte
  localparam logic [47:0] IDX_MODE = {8'hDF, 8'hDE, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
  localparam logic [47:0] IDX_CMP_LOW = {8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
  localparam logic [47:0] IDX_CMP_HIGH = {8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};
  // Control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WDT_BIT = 6;
  // Reset values, bus word size code, module count, watchdog module and tick divider default
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] CYCLE_RESET = 2'h0;
  localparam logic [1:0] HSIZE_WORD = 2'h2;
  localparam int NUM_MODULES = 6;
  localparam int WDT_MODULE = 5;
  localparam int TICK_DIV_DEFAULT = 1;

  // Mode control byte, bit 7 down to bit 0
  typedef struct packed {
    logic wide_modulation_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic module_flag_irq_enable;
  } pcam_mode_t;

  // Output function chosen by the mode byte
  typedef enum logic [2:0] {
    FN_IDLE = 3'b000,
    FN_TOGGLE = 3'b001,
    FN_PWM_SHORT = 3'b010,
    FN_PWM_WIDE = 3'b011,
    FN_FREQ = 3'b100
  } pcam_func_t;
endpackage : pcam_pkg

// [hw/pcam_chan.sv]
// One capture/compare module: edge capture, match, toggle, PWM and frequency output
`timescale 1ns/1ps
`default_nettype none
module pcam_chan (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cnt_new_i,
  input wire logic [15:0] count_i,
  input wire pcam_pkg::pcam_mode_t mode_i,
  input wire logic [15:0] compare_i,
  input wire logic [1:0] cycle_len_i,
  input wire logic capture_pin_i,
  output logic capture_o,
  output logic match_o,
  output logic module_output_pin_o
);
  logic pin_q;
  logic rise;
  logic fall;
  logic equal;
  logic short_hit;
  logic [15:0] mask;
  pcam_pkg::pcam_func_t func;

  // Period mask for 8 to 11-bit PWM
  function automatic logic [15:0] len_mask(input logic [1:0] sel);
    case (sel)
      2'h0: len_mask = 16'h00FF;
      2'h1: len_mask = 16'h01FF;
      2'h2: len_mask = 16'h03FF;
      default: len_mask = 16'h07FF;
    endcase
  endfunction : len_mask

  // Output function from the mode byte
  function automatic pcam_pkg::pcam_func_t pick_func(input pcam_pkg::pcam_mode_t m);
    if (!m.comparator_enable) begin
      pick_func = pcam_pkg::FN_IDLE;
    end else if (m.toggle_enable && m.pulse_width_enable) begin
      pick_func = pcam_pkg::FN_FREQ;
    end else if (m.pulse_width_enable && m.wide_modulation_select) begin
      pick_func = pcam_pkg::FN_PWM_WIDE;
    end else if (m.pulse_width_enable) begin
      pick_func = pcam_pkg::FN_PWM_SHORT;
    end else if (m.toggle_enable) begin
      pick_func = pcam_pkg::FN_TOGGLE;
    end else begin
      pick_func = pcam_pkg::FN_IDLE;
    end
  endfunction : pick_func

  // Input edge history
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= capture_pin_i;
    end
  end

  // Edge qualification and comparator
  assign rise = capture_pin_i & ~pin_q;
  assign fall = ~capture_pin_i & pin_q;
  assign capture_o = (mode_i.rising_capture_enable & rise) |
                     (mode_i.falling_capture_enable & fall); // [RULE3] [RULE4]
  assign equal = cnt_new_i && mode_i.comparator_enable && (count_i == compare_i); // [RULE2]
  assign short_hit = cnt_new_i && (count_i[7:0] == compare_i[7:0]);
  assign match_o = equal && mode_i.match_enable; // [RULE5]
  assign mask = len_mask(cycle_len_i); // [RULE16]
  assign func = pick_func(mode_i); // [RULE7]

  // Output pin waveform
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      module_output_pin_o <= 1'b0;
    end else begin
      case (func)
        pcam_pkg::FN_TOGGLE: begin
          if (equal) begin
            module_output_pin_o <= ~module_output_pin_o; // [RULE6]
          end
        end
        pcam_pkg::FN_FREQ: begin
          if (short_hit) begin
            module_output_pin_o <= ~module_output_pin_o; // [RULE7]
          end
        end
        pcam_pkg::FN_PWM_SHORT: begin
          module_output_pin_o <= (count_i & mask) >= (compare_i & mask); // [RULE1] [RULE8]
        end
        pcam_pkg::FN_PWM_WIDE: begin
          module_output_pin_o <= count_i >= compare_i; // [RULE1] [RULE8]
        end
        default: begin
          module_output_pin_o <= module_output_pin_o;
        end
      endcase
    end
  end

  // Toggle mode inverts the pin on every match
  a_toggle_pin: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE6]
    (func == pcam_pkg::FN_TOGGLE) && equal |=> module_output_pin_o != $past(module_output_pin_o))
    else $error("toggle match did not invert pin");
  // Wide PWM follows the full 16-bit compare
  a_wide_pwm: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE1]
    (func == pcam_pkg::FN_PWM_WIDE) |=> module_output_pin_o == ($past(count_i) >= $past(compare_i)))
    else $error("wide pwm level wrong");
endmodule : pcam_chan
`default_nettype wire

// [hw/pcam_top.sv]
// Counter array top: shared counter, six modules, mode registers and AHB-Lite slave
//
// How it works
// [RULE1] Wide select picks 16-bit over short PWM
// [RULE2] Comparator enable arms comparison against counter
// [RULE3] Rising capture enable captures on positive edges
// [RULE4] Falling capture enable captures on negative edges
// [RULE5] Match enable sets flag on counter equality
// [RULE6] Toggle enable inverts output pin on equality
// [RULE7] Toggle plus PWM gives frequency output
// [RULE8] PWM enable drives modulated waveform on pin
// [RULE9] Flag interrupt enable gates the module's request
// [RULE10] Watchdog enable locks module 5 mode register; compare byte writes to module 5 still clear or set its comparator enable
// [RULE11] Software clears watchdog before touching locked state
// [RULE12] Watchdog enable blocks counter low writes
// [RULE13] Watchdog enable blocks counter high writes
// [RULE14] High byte reads snapshot taken on low read
// [RULE15] Counter is 16 bits, two byte registers
// [RULE16] Cycle length field sets short PWM period
// [RULE17] Compare low write clears comparator enable
// [RULE18] Compare high write sets comparator enable
// [RULE19] Capture copies counter and sets the flag
// [RULE20] Counter increments each tick, wraps to zero
`timescale 1ns/1ps
`default_nettype none
module pcam_top #(
  parameter int TICK_DIV = pcam_pkg::TICK_DIV_DEFAULT,
  parameter int MODS = pcam_pkg::NUM_MODULES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [5:0] capture_pin_i,
  output logic [5:0] module_output_pin_o,
  output logic irq_req_o,
  output logic watchdog_expire_o
);
  // Bus data phase state
  logic ph_valid;
  logic ph_write;
  logic ph_ok;
  logic [7:0] ph_idx;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  // Block state
  logic [15:0] shared_array_counter;
  logic [7:0] high_snapshot;
  logic run;
  logic watchdog_enable;
  logic [1:0] cycle_length_select;
  logic [5:0] capture_compare_flag;
  pcam_pkg::pcam_mode_t module_mode_control [6];
  logic [15:0] compare [6];
  logic [15:0] tick_cnt;
  logic tick;
  logic cnt_new;
  logic [5:0] cap_ev;
  logic [5:0] match_ev;
  logic [5:0] eccf;
  logic [3:0] hit_mode;
  logic [3:0] hit_cmpl;
  logic [3:0] hit_cmph;

  // Finds which module an index belongs to: {hit, module number}
  function automatic logic [3:0] mod_of(input logic [7:0] idx, input logic [47:0] tbl);
    logic [3:0] r;
    r = 4'h0;
    for (int n = 0; n < 6; n++) begin
      if (tbl[n*8 +: 8] == idx) begin
        r = {1'b1, 3'(n)};
      end
    end
    mod_of = r;
  endfunction : mod_of

  // Address phase capture; the slave never stalls
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_ok <= 1'b0;
      ph_idx <= 8'h00;
    end else if (hready_i) begin
      ph_valid <= hsel_i && htrans_i[1];
      ph_write <= hwrite_i;
      ph_idx <= haddr_i[9:2];
      ph_ok <= (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'h0) &&
               (hsize_i[1:0] == pcam_pkg::HSIZE_WORD) && !hsize_i[2];
    end
  end

  // Data phase strobes and decode
  assign wr = ph_valid && ph_write && ph_ok;
  assign rd = ph_valid && !ph_write && ph_ok;
  assign wdata = hwdata_i[7:0];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hit_mode = mod_of(ph_idx, pcam_pkg::IDX_MODE);
  assign hit_cmpl = mod_of(ph_idx, pcam_pkg::IDX_CMP_LOW);
  assign hit_cmph = mod_of(ph_idx, pcam_pkg::IDX_CMP_HIGH);

  // Read data mux; unmapped indices read zero
  always_comb begin
    hrdata_o = 32'h00000000;
    if (!rd) begin
      hrdata_o = 32'h00000000;
    end else if (ph_idx == pcam_pkg::IDX_CNT_LOW) begin
      hrdata_o[7:0] = shared_array_counter[7:0]; // [RULE15]
    end else if (ph_idx == pcam_pkg::IDX_CNT_HIGH) begin
      hrdata_o[7:0] = high_snapshot; // [RULE14]
    end else if (ph_idx == pcam_pkg::IDX_CTRL) begin
      hrdata_o[pcam_pkg::CTRL_WDT_BIT] = watchdog_enable;
      hrdata_o[pcam_pkg::CTRL_RUN_BIT] = run;
    end else if (ph_idx == pcam_pkg::IDX_FLAGS) begin
      hrdata_o[5:0] = capture_compare_flag;
    end else if (ph_idx == pcam_pkg::IDX_CYCLE) begin
      hrdata_o[1:0] = cycle_length_select;
    end else if (hit_mode[3]) begin
      hrdata_o[7:0] = module_mode_control[hit_mode[2:0]];
    end else if (hit_cmpl[3]) begin
      hrdata_o[7:0] = compare[hit_cmpl[2:0]][7:0];
    end else if (hit_cmph[3]) begin
      hrdata_o[7:0] = compare[hit_cmph[2:0]][15:8];
    end
  end

  // Control and cycle-length registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run <= 1'b0;
      watchdog_enable <= 1'b0;
      cycle_length_select <= pcam_pkg::CYCLE_RESET;
    end else if (wr && ph_idx == pcam_pkg::IDX_CTRL) begin
      run <= wdata[pcam_pkg::CTRL_RUN_BIT];
      watchdog_enable <= wdata[pcam_pkg::CTRL_WDT_BIT];
    end else if (wr && ph_idx == pcam_pkg::IDX_CYCLE) begin
      cycle_length_select <= wdata[1:0]; // [RULE16]
    end
  end

  // Timebase divider: one-cycle tick enable
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= 16'h0000;
    end else if (!run || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = run && (tick_cnt == 16'(TICK_DIV - 1));

  // Shared counter; software writes win over a tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shared_array_counter <= pcam_pkg::CNT_RESET;
      cnt_new <= 1'b0;
    end else begin
      cnt_new <= tick;
      if (wr && ph_idx == pcam_pkg::IDX_CNT_LOW) begin
        if (!watchdog_enable) begin
          shared_array_counter[7:0] <= wdata; // [RULE12]
        end
      end else if (wr && ph_idx == pcam_pkg::IDX_CNT_HIGH) begin
        if (!watchdog_enable) begin
          shared_array_counter[15:8] <= wdata; // [RULE13]
        end
      end else if (tick) begin
        shared_array_counter <= shared_array_counter + 16'h0001; // [RULE20]
      end
    end
  end

  // High byte snapshot loads only on a low-byte read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_snapshot <= 8'h00;
    end else if (rd && ph_idx == pcam_pkg::IDX_CNT_LOW) begin
      high_snapshot <= shared_array_counter[15:8]; // [RULE14]
    end
  end

  // Mode registers; compare writes steer the comparator enable
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int n = 0; n < 6; n++) begin
        module_mode_control[n] <= pcam_pkg::MODE_RESET;
      end
    end else begin
      for (int n = 0; n < 6; n++) begin
        if (wr && hit_mode == {1'b1, 3'(n)}) begin
          if (!(n == pcam_pkg::WDT_MODULE && watchdog_enable)) begin
            module_mode_control[n] <= wdata; // [RULE10]
          end
        end else if (wr && hit_cmpl == {1'b1, 3'(n)}) begin
          module_mode_control[n].comparator_enable <= 1'b0; // [RULE17]
        end else if (wr && hit_cmph == {1'b1, 3'(n)}) begin
          module_mode_control[n].comparator_enable <= 1'b1; // [RULE18]
        end
      end
    end
  end

  // Compare registers; captures load the counter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int n = 0; n < 6; n++) begin
        compare[n] <= 16'h0000;
      end
    end else begin
      for (int n = 0; n < 6; n++) begin
        if (wr && hit_cmpl == {1'b1, 3'(n)}) begin
          compare[n][7:0] <= wdata;
        end else if (wr && hit_cmph == {1'b1, 3'(n)}) begin
          compare[n][15:8] <= wdata;
        end else if (cap_ev[n]) begin
          compare[n] <= shared_array_counter; // [RULE19]
        end
      end
    end
  end

  // Sticky flags: write 0 clears, a hardware set wins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      capture_compare_flag <= 6'h00;
    end else if (wr && ph_idx == pcam_pkg::IDX_FLAGS) begin
      capture_compare_flag <= (capture_compare_flag & wdata[5:0]) | cap_ev | match_ev; // [RULE5]
    end else begin
      capture_compare_flag <= capture_compare_flag | cap_ev | match_ev; // [RULE19]
    end
  end

  // Watchdog expiry on module 5 high-byte match
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      watchdog_expire_o <= 1'b0;
    end else begin
      watchdog_expire_o <= watchdog_enable && cnt_new &&
        (shared_array_counter[15:8] == compare[pcam_pkg::WDT_MODULE][15:8]); // [RULE10]
    end
  end

  // Modules; module 5 is silenced while it serves as watchdog
  for (genvar g = 0; g < 6; g++) begin : g_mod
    pcam_pkg::pcam_mode_t eff_mode;
    assign eff_mode = (g == pcam_pkg::WDT_MODULE && watchdog_enable) ?
                      pcam_pkg::pcam_mode_t'(pcam_pkg::MODE_RESET) : module_mode_control[g];
    assign eccf[g] = eff_mode.module_flag_irq_enable;
    pcam_chan u_chan (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .cnt_new_i(cnt_new),
      .count_i(shared_array_counter),
      .mode_i(eff_mode),
      .compare_i(compare[g]),
      .cycle_len_i(cycle_length_select),
      .capture_pin_i(capture_pin_i[g]),
      .capture_o(cap_ev[g]),
      .match_o(match_ev[g]),
      .module_output_pin_o(module_output_pin_o[g])
    );
  end

  // Interrupt request from enabled flags
  assign irq_req_o = |(capture_compare_flag & eccf); // [RULE9]

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_wdt_mode5_write;
    watchdog_enable && wr && hit_mode == 4'hD;
  endsequence

  // Mode 5 writes ignored while the watchdog owns it
  a_wdt_mode_lock: assert property (s_wdt_mode5_write // [RULE10]
    |=> $stable(module_mode_control[5]))
    else $error("module 5 mode changed under watchdog");

  // Module 5 raises no capture or match as watchdog
  a_wdt_silence: assert property (watchdog_enable // [RULE10]
    |-> !cap_ev[pcam_pkg::WDT_MODULE] && !match_ev[pcam_pkg::WDT_MODULE])
    else $error("module 5 acted as a normal module");

  // Counter bytes locked while the watchdog runs
  a_cnt_low_lock: assert property (watchdog_enable && wr && !tick // [RULE12]
    && ph_idx == pcam_pkg::IDX_CNT_LOW |=> $stable(shared_array_counter))
    else $error("counter low written under watchdog");

  a_cnt_high_lock: assert property (watchdog_enable && wr && !tick // [RULE13]
    && ph_idx == pcam_pkg::IDX_CNT_HIGH |=> $stable(shared_array_counter))
    else $error("counter high written under watchdog");

  // High byte snapshot loads on low reads only
  a_snap_load: assert property (rd && ph_idx == pcam_pkg::IDX_CNT_LOW // [RULE14]
    |=> high_snapshot == $past(shared_array_counter[15:8]))
    else $error("snapshot not loaded on low read");

  a_snap_hold: assert property (!(rd && ph_idx == pcam_pkg::IDX_CNT_LOW) // [RULE14]
    |=> $stable(high_snapshot))
    else $error("snapshot changed without low read");

  // Compare byte writes steer the comparator enable
  a_cmpl_clears: assert property (wr && hit_cmpl == 4'h8 // [RULE17]
    |=> !module_mode_control[0].comparator_enable)
    else $error("compare low write left comparator enabled");

  a_cmph_sets: assert property (wr && hit_cmph == 4'h8 // [RULE18]
    |=> module_mode_control[0].comparator_enable)
    else $error("compare high write did not enable comparator");

  // Capture loads the counter and sets the flag
  a_capture_load: assert property (cap_ev[0] && !(wr && (hit_cmpl[3] || hit_cmph[3])) // [RULE19]
    |=> compare[0] == $past(shared_array_counter) && capture_compare_flag[0])
    else $error("capture did not load counter and flag");

  // Match sets its module flag
  a_match_flag: assert property (match_ev[2] |=> capture_compare_flag[2]) // [RULE5]
    else $error("match did not set flag");

  // Enabled flag raises the request
  a_irq_follow: assert property (cap_ev[0] && eccf[0] ##1 eccf[0] |-> irq_req_o) // [RULE9]
    else $error("enabled flag raised no request");

  // Counter steps by one on each tick
  a_counter_step: assert property (tick && !wr // [RULE20]
    |=> shared_array_counter == $past(shared_array_counter) + 16'h0001)
    else $error("counter did not step on tick");

  // Counter wraps from all ones to zero
  a_counter_wrap: assert property (tick && !wr && shared_array_counter == 16'hFFFF // [RULE20]
    |=> shared_array_counter == 16'h0000 && cnt_new)
    else $error("counter did not wrap to zero");
endmodule : pcam_top
`default_nettype wire

// [bench/pcam_pin_model.sv]
// Pin-side partner: drives the capture inputs and counts changes on the output pins
`timescale 1ns/1ps
`default_nettype none
module pcam_pin_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] level_i,
  output logic [5:0] capture_pin_o,
  input wire logic [5:0] module_output_pin_i,
  output logic [47:0] flips_o
);
  logic [5:0] last_pin;

  // Capture inputs change just after an edge, like a synchronised source
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      capture_pin_o <= 6'h00;
    end else begin
      capture_pin_o <= level_i;
    end
  end

  // One 8-bit change counter per output pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_pin <= 6'h00;
      flips_o <= 48'h0;
    end else begin
      last_pin <= module_output_pin_i;
      for (int i = 0; i < 6; i++) begin
        if (module_output_pin_i[i] != last_pin[i]) begin
          flips_o[8*i +: 8] <= flips_o[8*i +: 8] + 8'h01;
        end
      end
    end
  end
endmodule : pcam_pin_model
`default_nettype wire

// [bench/pcam_module_mode_and_counter_bench.sv]
// Testbench: register accesses over AHB-Lite and pin checks of the counter array
`timescale 1ns/1ps
`default_nettype none
module pcam_module_mode_and_counter_bench;
  localparam logic [7:0] RUN = 8'(1 << pcam_pkg::CTRL_RUN_BIT);
  localparam logic [7:0] WDT = 8'(1 << pcam_pkg::CTRL_WDT_BIT);
  logic clk_i, rstn_i, hsel, hwrite, hreadyout, hresp, irq_req, wd_expire, wd_seen;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [5:0] pin_level, capture_pin, out_pin;
  logic [47:0] flips;
  logic [7:0] lo, hi, f0, f4;
  int fails, samples_checked, cycles;

  pcam_top #(.TICK_DIV(1), .MODS(6)) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .capture_pin_i(capture_pin), .module_output_pin_o(out_pin), .irq_req_o(irq_req),
    .watchdog_expire_o(wd_expire));

  pcam_pin_model i_pins (.clk_i(clk_i), .rstn_i(rstn_i), .level_i(pin_level),
    .capture_pin_o(capture_pin), .module_output_pin_i(out_pin), .flips_o(flips));

  // Clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // Remembers any watchdog expiry pulse
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      wd_seen <= 1'b0;
    end else if (wd_expire) begin
      wd_seen <= 1'b1;
    end
  end

  function automatic logic [7:0] idx(input logic [47:0] tbl, input int n);
    return tbl[8*n +: 8];
  endfunction : idx

  // Number of post-tick counter values 1..c matching the compare under a mask
  function automatic logic [7:0] hits(input logic [15:0] c, input logic [15:0] p,
                                      input logic [15:0] m);
    int n;
    n = 0;
    for (int k = 1; k <= c; k++) begin
      if ((k[15:0] & m) == (p & m)) n++;
    end
    return 8'(n);
  endfunction : hits

  // Short or wide PWM level for a stopped counter
  function automatic logic [7:0] pwm(input logic [15:0] c, input logic [15:0] p,
                                     input logic [1:0] code, input logic wide);
    logic [15:0] m;
    m = wide ? 16'hFFFF : (16'h0100 << code) - 16'h0001;
    return {7'h00, (c & m) >= (p & m)};
  endfunction : pwm

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] ix, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {22'h0, ix, 2'h0};
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    rd = hrdata[7:0];
  endtask : bus

  task automatic wr8(input logic [7:0] ix, input logic [7:0] wd);
    logic [7:0] dummy;
    bus(1'b1, ix, wd, dummy);
  endtask : wr8

  task automatic rd8(input logic [7:0] ix, output logic [7:0] rd);
    bus(1'b0, ix, 8'h00, rd);
  endtask : rd8

  task automatic rdchk(input logic [7:0] ix, input logic [7:0] exp);
    logic [7:0] v;
    rd8(ix, v);
    check(v, exp);
  endtask : rdchk

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    pin_level = 6'h00;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    // Reset values and an unmapped place
    rdchk(pcam_pkg::IDX_CNT_LOW, pcam_pkg::CNT_RESET[7:0]);
    rdchk(pcam_pkg::IDX_CNT_HIGH, pcam_pkg::CNT_RESET[15:8]);
    for (int n = 0; n < 6; n++) rdchk(idx(pcam_pkg::IDX_MODE, n), pcam_pkg::MODE_RESET);
    wr8(8'h10, 8'hA5);
    rdchk(8'h10, 8'h00);
    $display("reset values done");
    // Counter bytes and the high-byte snapshot
    wr8(pcam_pkg::IDX_CNT_LOW, 8'h34);
    wr8(pcam_pkg::IDX_CNT_HIGH, 8'h12);
    rdchk(pcam_pkg::IDX_CNT_LOW, 8'h34);
    rdchk(pcam_pkg::IDX_CNT_HIGH, 8'h12);
    wr8(pcam_pkg::IDX_CNT_HIGH, 8'h56);
    rdchk(pcam_pkg::IDX_CNT_HIGH, 8'h12);
    rdchk(pcam_pkg::IDX_CNT_LOW, 8'h34);
    rdchk(pcam_pkg::IDX_CNT_HIGH, 8'h56);
    $display("snapshot done");
    // Watchdog lock; mode 5 takes a write only while the watchdog is off
    wr8(idx(pcam_pkg::IDX_MODE, 5), 8'h49);
    wr8(pcam_pkg::IDX_CTRL, WDT);
    wr8(pcam_pkg::IDX_CNT_LOW, 8'hAA);
    wr8(pcam_pkg::IDX_CNT_HIGH, 8'hBB);
    wr8(idx(pcam_pkg::IDX_MODE, 5), 8'h00);
    rdchk(idx(pcam_pkg::IDX_MODE, 5), 8'h49);
    rdchk(pcam_pkg::IDX_CNT_LOW, 8'h34);
    rdchk(pcam_pkg::IDX_CNT_HIGH, 8'h56);
    wr8(pcam_pkg::IDX_CTRL, 8'h00);
    wr8(idx(pcam_pkg::IDX_MODE, 5), 8'h00);
    rdchk(idx(pcam_pkg::IDX_MODE, 5), 8'h00);
    $display("watchdog lock done");
    // Edge capture with the counter stopped at 0x5634
    wr8(idx(pcam_pkg::IDX_MODE, 0), 8'h21);
    wr8(idx(pcam_pkg::IDX_MODE, 1), 8'h10);
    pin_level <= 6'h03;
    repeat (4) @(posedge clk_i);
    check({7'h00, irq_req}, 8'h01);
    rdchk(pcam_pkg::IDX_FLAGS, 8'h01);
    rdchk(idx(pcam_pkg::IDX_CMP_LOW, 0), 8'h34);
    rdchk(idx(pcam_pkg::IDX_CMP_HIGH, 0), 8'h56);
    wr8(pcam_pkg::IDX_FLAGS, 8'h00);
    pin_level <= 6'h01;
    repeat (4) @(posedge clk_i);
    rdchk(pcam_pkg::IDX_FLAGS, 8'h02);
    check({7'h00, irq_req}, 8'h00);
    $display("capture done");
    // Running counter: match, comparator enable, toggle and frequency output
    wr8(pcam_pkg::IDX_CNT_LOW, 8'h00);
    wr8(pcam_pkg::IDX_CNT_HIGH, 8'h00);
    wr8(idx(pcam_pkg::IDX_MODE, 2), 8'h48);
    wr8(idx(pcam_pkg::IDX_CMP_LOW, 2), 8'h05);
    rdchk(idx(pcam_pkg::IDX_MODE, 2), 8'h08);
    wr8(idx(pcam_pkg::IDX_CMP_HIGH, 2), 8'h00);
    rdchk(idx(pcam_pkg::IDX_MODE, 2), 8'h48);
    wr8(idx(pcam_pkg::IDX_MODE, 3), 8'h08);
    wr8(idx(pcam_pkg::IDX_CMP_LOW, 3), 8'h05);
    wr8(idx(pcam_pkg::IDX_MODE, 4), 8'h04);
    wr8(idx(pcam_pkg::IDX_CMP_LOW, 4), 8'h05);
    wr8(idx(pcam_pkg::IDX_CMP_HIGH, 4), 8'h00);
    wr8(idx(pcam_pkg::IDX_MODE, 0), 8'h06);
    wr8(idx(pcam_pkg::IDX_CMP_LOW, 0), 8'h03);
    wr8(idx(pcam_pkg::IDX_CMP_HIGH, 0), 8'h00);
    wr8(pcam_pkg::IDX_FLAGS, 8'h00);
    f0 = flips[7:0];
    f4 = flips[39:32];
    wr8(pcam_pkg::IDX_CTRL, RUN);
    repeat (600) @(posedge clk_i);
    wr8(pcam_pkg::IDX_CTRL, 8'h00);
    repeat (4) @(posedge clk_i);
    rd8(pcam_pkg::IDX_CNT_LOW, lo);
    rd8(pcam_pkg::IDX_CNT_HIGH, hi);
    rdchk(pcam_pkg::IDX_FLAGS, 8'h04);
    check({7'h00, irq_req}, 8'h00);
    check(flips[39:32] - f4, hits({hi, lo}, 16'h0005, 16'hFFFF));
    check(flips[7:0] - f0, hits({hi, lo}, 16'h0003, 16'h00FF));
    $display("match and toggle done");
    // PWM levels for each cycle length, and 16-bit PWM on module 5
    wr8(pcam_pkg::IDX_CNT_LOW, 8'h80);
    wr8(pcam_pkg::IDX_CNT_HIGH, 8'h02);
    wr8(idx(pcam_pkg::IDX_MODE, 1), 8'h02);
    wr8(idx(pcam_pkg::IDX_CMP_LOW, 1), 8'h80);
    wr8(idx(pcam_pkg::IDX_CMP_HIGH, 1), 8'h01);
    wr8(idx(pcam_pkg::IDX_MODE, 5), 8'h82);
    wr8(idx(pcam_pkg::IDX_CMP_LOW, 5), 8'h90);
    wr8(idx(pcam_pkg::IDX_CMP_HIGH, 5), 8'h01);
    for (int code = 0; code < 4; code++) begin
      wr8(pcam_pkg::IDX_CYCLE, 8'(code));
      repeat (4) @(posedge clk_i);
      check({7'h00, out_pin[1]}, pwm(16'h0280, 16'h0180, 2'(code), 1'b0));
      check({7'h00, out_pin[5]}, pwm(16'h0280, 16'h0190, 2'(code), 1'b1));
    end
    $display("pwm done");
    // Wrap from all ones
    wr8(pcam_pkg::IDX_CNT_LOW, 8'hFF);
    wr8(pcam_pkg::IDX_CNT_HIGH, 8'hFF);
    wr8(pcam_pkg::IDX_CTRL, RUN);
    wr8(pcam_pkg::IDX_CTRL, 8'h00);
    rd8(pcam_pkg::IDX_CNT_LOW, lo);
    rd8(pcam_pkg::IDX_CNT_HIGH, hi);
    check(hi, 8'h00);
    check({7'h00, lo < 8'h10}, 8'h01);
    $display("wrap done");
    // Watchdog expiry on a module 5 high byte match
    check({7'h00, wd_seen}, 8'h00);
    wr8(idx(pcam_pkg::IDX_CMP_HIGH, 5), 8'h00);
    wr8(pcam_pkg::IDX_CTRL, RUN | WDT);
    repeat (4) @(posedge clk_i);
    wr8(pcam_pkg::IDX_CTRL, 8'h00);
    check({7'h00, wd_seen}, 8'h01);
    $display("watchdog expiry done");
    results();
  end
endmodule : pcam_module_mode_and_counter_bench
`default_nettype wire
